// >>> verilog/memmap_mode.sv
// Memory map decoder, mode status register, vector pointer and saturation logic.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module memmap_mode
  import memmap_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 rom_select,
  input  wire logic                 memory_protect,
  input  wire logic                 soft_reset,
  input  wire logic                 prog_rd,
  input  wire logic                 prog_wr,
  input  wire logic [PROG_AW-1:0]   prog_addr,
  input  wire logic [WORD_W-1:0]    prog_wdata,
  output logic      [WORD_W-1:0]    prog_rdata,
  output logic                      prog_ram_hit,
  output logic                      prog_rom_hit,
  output logic                      prog_ext,
  input  wire logic                 data_rd,
  input  wire logic                 data_wr,
  input  wire logic [DATA_AW-1:0]   data_addr,
  input  wire logic [WORD_W-1:0]    data_wdata,
  output logic      [WORD_W-1:0]    data_rdata,
  output logic                      data_ram_hit,
  output logic                      data_page0,
  output logic                      data_ext,
  input  wire logic                 hp_rd,
  input  wire logic                 hp_wr,
  input  wire logic [DATA_AW-1:0]   hp_addr,
  input  wire logic [WORD_W-1:0]    hp_wdata,
  output logic      [WORD_W-1:0]    hp_rdata,
  output logic                      hp_wait,
  output logic                      hp_denied,
  input  wire logic                 ext_instr_req,
  output logic                      ext_instr_grant,
  output logic                      ext_instr_denied,
  input  wire logic                 vec_take,
  input  wire logic [4:0]           vec_num,
  output logic                      pc_load,
  output logic      [PROG_AW-1:0]   pc_value,
  output logic      [PROG_AW-1:0]   ext_addr_pins,
  output logic                      clock_output_pin,
  input  wire logic                 overflow_mode,
  input  wire logic                 fractional_mode,
  input  wire logic                 multiply_accumulate_op,
  input  wire logic                 multiply_subtract_op,
  input  wire logic [31:0]          product_in,
  output logic      [31:0]          product_out,
  input  wire logic                 store_req,
  input  wire logic [39:0]          acc_in,
  input  wire logic [4:0]           store_shift,
  output logic      [31:0]          store_data
);

  // ---------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------
  // Data-space decode, shared by the core data bus and the host port.
  function automatic logic [4:0] dec_data(input logic [15:0] a, input logic map_upper);
    logic [4:0] r;
    r = 5'h00;
    if (!a[15] && a > PAGE0_END)
      r = {2'b10, 1'b0, a[14:13]};
    else if (a[15] && map_upper)
      r = {2'b10, 1'b1, a[14:13]};
    return r;
  endfunction

  // Program-space decode: hit flag then bank index.
  function automatic logic [4:0] dec_prog(input logic [22:0] a, input logic overlay);
    logic [4:0] r;
    r = 5'h00;
    if (overlay && !a[15] && a[15:0] > PAGE0_END)
      r = {2'b10, 1'b0, a[14:13]};
    else if (a[15] && a[22:16] == UPPER_DUAL_PG)
      r = {2'b10, 1'b1, a[14:13]};
    else if (a[15] && (a[22:16] == SINGLE_PG_A || a[22:16] == SINGLE_PG_B))
      r = {1'b1, 1'b1, a[16], a[14:13]};
    return r;
  endfunction

  // Arithmetic shift of the accumulator followed by optional 32-bit saturation.
  function automatic logic [31:0] store_sat(input logic [39:0] acc, input logic [4:0] sh,
                                            input logic en);
    logic signed [39:0] s;
    logic [4:0]         amt;
    s   = signed'(acc);
    amt = 5'(~sh + 5'h01);
    if (sh[4])
      s = s >>> amt;
    else
      s = s <<< sh;
    if (en && !(&s[39:31] || ~|s[39:31]))
      return s[39] ? SAT_NEG : SAT_POS;
    return s[31:0];
  endfunction

  // ---------------------------------------------------------------
  // Mode status register and APB slave
  // ---------------------------------------------------------------
  logic [15:0] mode_q;
  logic        strap_done_q;
  logic        wr_mode;
  logic        setup;
  logic        mapped;
  logic [31:0] rd_mux;

  assign setup   = psel && !penable;
  assign mapped  = (paddr == MODE_OFS) || (paddr == STATUS_OFS);
  assign wr_mode = psel && penable && pwrite && (paddr == MODE_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Register writes land at the access edge, so the decoder sees them next cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= MODE_RST;
    else if (!strap_done_q)
      mode_q[ROM_SEL_BIT] <= rom_select;
    else if (wr_mode)
    begin
      if (pstrb[0])
        mode_q[7:0] <= pwdata[7:0];
      if (pstrb[1])
        mode_q[15:8] <= pwdata[15:8];
    end
    else if (soft_reset)
      mode_q[OVERLAY_BIT:0] <= MODE_RST[OVERLAY_BIT:0];
  end

  // The strap is caught once, on the first edge after reset release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strap_done_q <= 1'b0;
    else
      strap_done_q <= 1'b1;
  end

  // Read data is prepared in the setup cycle, so it is a flop in the access phase.
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (paddr == MODE_OFS)
      rd_mux = {16'h0000, mode_q};
    else if (paddr == STATUS_OFS)
      rd_mux = {29'h0, hp_denied, strap_done_q, memory_protect};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= rd_mux;
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [4:0] pdec;
  logic [4:0] ddec;
  logic [4:0] hdec;
  logic       prog_req;
  logic       data_req;
  logic       hp_req;
  logic       hp_go;

  assign pdec     = dec_prog(prog_addr, mode_q[OVERLAY_BIT]);
  assign ddec     = dec_data(data_addr, mode_q[DATA_MAP_BIT]);
  assign hdec     = dec_data(hp_addr, mode_q[DATA_MAP_BIT]);
  assign prog_req = prog_rd || prog_wr;
  assign data_req = data_rd || data_wr;
  assign hp_req   = hp_rd || hp_wr;

  assign prog_ram_hit = prog_req && pdec[4];
  assign prog_rom_hit = prog_req && !pdec[4] && !mode_q[ROM_SEL_BIT]
                        && prog_addr[22:16] == 7'h00 && prog_addr[15:0] >= ROM_LO;
  assign prog_ext     = prog_req && !prog_ram_hit && !prog_rom_hit;
  assign data_page0   = data_req && data_addr <= PAGE0_END;
  assign data_ram_hit = data_req && ddec[4];
  assign data_ext     = data_req && !ddec[4] && !data_page0;

  // Host port yields the data-side port to the core; reads may be fenced off.
  assign hp_denied = hp_rd && memory_protect
                     && (hp_addr < HOST_RD_LO || hp_addr > HOST_RD_HI);
  assign hp_wait   = hp_req && data_req;
  assign hp_go     = hp_req && !hp_wait && !hp_denied && hdec[4];

  // External instruction fetches never reach on-chip memory while protected.
  assign ext_instr_denied = ext_instr_req && memory_protect;
  assign ext_instr_grant  = ext_instr_req && !memory_protect;

  // ---------------------------------------------------------------
  // Bank port steering
  // ---------------------------------------------------------------
  logic        a_en  [NUM_BANKS];
  logic        a_we  [NUM_BANKS];
  logic [12:0] a_ad  [NUM_BANKS];
  logic [15:0] a_wd  [NUM_BANKS];
  logic [15:0] a_rd  [NUM_BANKS];
  logic        b_en  [NUM_BANKS];
  logic [15:0] b_rd  [NUM_BANKS];

  // Dual banks: port A data/host, port B program. Single banks: port A program.
  always_comb
  begin
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      a_en[i] = 1'b0;
      a_we[i] = 1'b0;
      a_ad[i] = 13'h0000;
      a_wd[i] = 16'h0000;
      b_en[i] = 1'b0;
      if (i < NUM_DUAL)
      begin
        b_en[i] = prog_ram_hit && pdec[3:0] == 4'(i);
        if (data_ram_hit && ddec[3:0] == 4'(i))
        begin
          a_en[i] = 1'b1;
          a_we[i] = data_wr;
          a_ad[i] = data_addr[12:0];
          a_wd[i] = data_wdata;
        end
        else if (hp_go && hdec[3:0] == 4'(i))
        begin
          a_en[i] = 1'b1;
          a_we[i] = hp_wr;
          a_ad[i] = hp_addr[12:0];
          a_wd[i] = hp_wdata;
        end
      end
      else if (prog_ram_hit && pdec[3:0] == 4'(i))
      begin
        a_en[i] = 1'b1;
        a_we[i] = prog_wr;
        a_ad[i] = prog_addr[12:0];
        a_wd[i] = prog_wdata;
      end
    end
  end

  ram_port_if pa [NUM_BANKS] ();
  ram_port_if pb [NUM_BANKS] ();

  // Every bank is the same two-port macro; single banks leave port B idle.
  for (genvar g = 0; g < NUM_BANKS; g++)
  begin : bank_g
    assign pa[g].en    = a_en[g];
    assign pa[g].we    = a_we[g];
    assign pa[g].addr  = a_ad[g];
    assign pa[g].wdata = a_wd[g];
    assign a_rd[g]     = pa[g].rdata;
    assign pb[g].en    = b_en[g];
    assign pb[g].we    = prog_wr;
    assign pb[g].addr  = prog_addr[12:0];
    assign pb[g].wdata = prog_wdata;
    assign b_rd[g]     = pb[g].rdata;
    ram_bank u_bank
    (
      .pclk    (pclk),
      .presetn (presetn),
      .pa      (pa[g]),
      .pb      (pb[g])
    );
  end

  // ---------------------------------------------------------------
  // Read return
  // ---------------------------------------------------------------
  logic [4:0] prd_q;
  logic [4:0] drd_q;
  logic [4:0] hrd_q;

  // Remember which bank answers; the bank output flops then feed the bus.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prd_q <= 5'h00;
      drd_q <= 5'h00;
      hrd_q <= 5'h00;
    end
    else
    begin
      prd_q <= {prog_ram_hit && prog_rd, pdec[3:0]};
      drd_q <= {data_ram_hit && data_rd, ddec[3:0]};
      hrd_q <= {hp_go && hp_rd, hdec[3:0]};
    end
  end

  assign prog_rdata = !prd_q[4] ? 16'h0000 :
                      (prd_q[3] ? a_rd[prd_q[3:0]] : b_rd[prd_q[3:0]]);
  assign data_rdata = drd_q[4] ? a_rd[drd_q[3:0]] : 16'h0000;
  assign hp_rdata   = hrd_q[4] ? a_rd[hrd_q[3:0]] : 16'h0000;

  // ---------------------------------------------------------------
  // Vector fetch
  // ---------------------------------------------------------------
  // The first edge after release issues the hardware reset vector.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_load  <= 1'b0;
      pc_value <= 23'h000000;
    end
    else if (!strap_done_q)
    begin
      pc_load  <= 1'b1;
      pc_value <= {7'h00, RESET_VECTOR};
    end
    else if (vec_take)
    begin
      pc_load  <= 1'b1;
      pc_value <= {7'h00, mode_q[VEC_PTR_MSB:VEC_PTR_LSB], vec_num, 2'b00};
    end
    else
      pc_load <= 1'b0;
  end

  // ---------------------------------------------------------------
  // External pins
  // ---------------------------------------------------------------
  // Without visibility the pins keep the last external bus address.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_addr_pins <= 23'h000000;
    else if (prog_ext || (prog_req && mode_q[ADDR_VIS_BIT]))
      ext_addr_pins <= prog_addr;
    else if (data_ext)
      ext_addr_pins <= {7'h00, data_addr};
  end

  // Clock output runs at half the core rate unless parked high.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_output_pin <= 1'b0;
    else if (mode_q[CLK_OFF_BIT])
      clock_output_pin <= 1'b1;
    else
      clock_output_pin <= ~clock_output_pin;
  end

  // ---------------------------------------------------------------
  // Saturation
  // ---------------------------------------------------------------
  logic prod_sat_en;

  assign prod_sat_en = mode_q[PROD_SAT_BIT] && overflow_mode && fractional_mode;

  // Only the fractional 8000h x 8000h product can overflow 32 bits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      product_out <= 32'h00000000;
    else if (multiply_accumulate_op || multiply_subtract_op)
      product_out <= (prod_sat_en && product_in == SAT_NEG) ? SAT_POS : product_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      store_data <= 32'h00000000;
    else if (store_req)
      store_data <= store_sat(acc_in, store_shift, mode_q[STORE_SAT_BIT]);
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // The sampled reset level keeps the release edge itself, still in reset, out of the strap checks.
  reset_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !strap_done_q |=> pc_load && pc_value == 23'h00ff80)
    else $error("Reset vector not issued at FF80h.");

  vec_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done_q && vec_take |=> pc_load &&
      pc_value[15:0] == {$past(mode_q[15:7]), $past(vec_num), 2'b00})
    else $error("Vector address not formed from pointer page.");

  soft_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done_q && soft_reset && !wr_mode
      |=> $stable(mode_q[15:6]) && mode_q[5:0] == 6'h00)
    else $error("Software reset altered pointer or ROM select.");

  strap_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !strap_done_q |=> mode_q[6] == $past(rom_select))
    else $error("ROM select strap not captured.");

  page0_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    prog_req && prog_addr[15:0] <= 16'h007f && prog_addr[22:16] != 7'h01
      |-> !prog_ram_hit || prog_addr[15])
    else $error("Page 0 mapped into program space.");

  host_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    hp_rd && memory_protect && hp_addr[15:13] != 3'b010
      |-> hp_denied ##1 hp_rdata == 16'h0000)
    else $error("Protected host read outside window served.");

  instr_prot_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_instr_req
      |-> ext_instr_denied == memory_protect && ext_instr_grant != memory_protect)
    else $error("External instruction protection wrong.");

  upper_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_req && data_addr[15]
      |-> data_ram_hit == mode_q[3] && data_ext == !mode_q[3])
    else $error("Upper data map wrong.");

  clk_park_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q[2] [*2] |-> clock_output_pin)
    else $error("Clock output not parked high.");

  single_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
    prog_req && prog_addr[22:16] == 7'h03 && prog_addr[15]
      |-> prog_ram_hit && pdec[3])
    else $error("Single-access RAM not decoded.");

endmodule

// >>> inc/memmap_pkg.sv
// Constants, field positions and reset values of the on-chip memory map and mode logic.
package memmap_pkg;

  // ---------------------------------------------------------------
  // Memory organisation
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned BANK_AW     = 13;      // 8K words per bank.
  localparam int unsigned NUM_DUAL    = 8;
  localparam int unsigned NUM_BANKS   = 16;      // Eight dual-access then eight single-access.
  localparam int unsigned PROG_AW     = 23;
  localparam int unsigned DATA_AW     = 16;

  // ---------------------------------------------------------------
  // Address ranges
  // ---------------------------------------------------------------
  localparam logic [15:0] PAGE0_END      = 16'h007f;  // Data page 0 never holds RAM.
  localparam logic [15:0] HOST_RD_LO     = 16'h4000;
  localparam logic [15:0] HOST_RD_HI     = 16'h5fff;
  localparam logic [15:0] ROM_LO         = 16'hc000;
  localparam logic [6:0]  UPPER_DUAL_PG  = 7'h01;    // 18000h-1FFFFh.
  localparam logic [6:0]  SINGLE_PG_A    = 7'h02;    // 28000h-2FFFFh.
  localparam logic [6:0]  SINGLE_PG_B    = 7'h03;    // 38000h-3FFFFh.

  // ---------------------------------------------------------------
  // APB register map
  // ---------------------------------------------------------------
  localparam logic [11:0] MODE_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;

  // ---------------------------------------------------------------
  // Mode status register fields
  // ---------------------------------------------------------------
  localparam int unsigned VEC_PTR_LSB   = 7;
  localparam int unsigned VEC_PTR_MSB   = 15;
  localparam int unsigned ROM_SEL_BIT   = 6;
  localparam int unsigned OVERLAY_BIT   = 5;
  localparam int unsigned ADDR_VIS_BIT  = 4;
  localparam int unsigned DATA_MAP_BIT  = 3;
  localparam int unsigned CLK_OFF_BIT   = 2;
  localparam int unsigned PROD_SAT_BIT  = 1;
  localparam int unsigned STORE_SAT_BIT = 0;
  localparam logic [8:0]  VEC_PTR_RST   = 9'h1ff;
  localparam logic [15:0] MODE_RST      = 16'hff80;  // Bit 6 is replaced by the strap.
  localparam int unsigned VEC_WORDS_LG2 = 2;         // Four words per vector.
  localparam logic [15:0] RESET_VECTOR  = 16'hff80;

  // ---------------------------------------------------------------
  // Saturation limits
  // ---------------------------------------------------------------
  localparam logic [31:0] SAT_POS = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG = 32'h80000000;

endpackage

// >>> inc/ram_port_if.sv
// One access port of an on-chip RAM bank.
`timescale 1ns/1ps
interface ram_port_if;
  logic        en;
  logic        we;
  logic [12:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport user (output en, output we, output addr, output wdata, input rdata);
  modport bank (input en, input we, input addr, input wdata, output rdata);
endinterface

// >>> verilog/ram_bank.sv
// One 8K x 16 RAM bank with two independent synchronous ports.
`timescale 1ns/1ps
module ram_bank
  import memmap_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  ram_port_if.bank    pa,
  ram_port_if.bank    pb
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:(1<<BANK_AW)-1];

  // Two writers to one word in one cycle is left to the caller; port B wins.
  always_ff @(posedge pclk)
  begin
    if (pa.en && pa.we)
      mem[pa.addr] <= pa.wdata;
    if (pb.en && pb.we)
      mem[pb.addr] <= pb.wdata;
  end

  // Read data of both ports, one cycle after the request.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa.rdata <= 16'h0000;
      pb.rdata <= 16'h0000;
    end
    else
    begin
      if (pa.en && !pa.we)
        pa.rdata <= mem[pa.addr];
      if (pb.en && !pb.we)
        pb.rdata <= mem[pb.addr];
    end
  end

endmodule

// >>> verif/host_model.sv
// Host port partner model that holds a read request while the core keeps it waiting.
`timescale 1ns/1ps
module host_model (
  input  wire logic        pclk,
  input  wire logic        hp_wait,
  input  wire logic        hp_denied,
  output logic             hp_rd,
  output logic             hp_wr,
  output logic [15:0]      hp_addr,
  output logic [15:0]      hp_wdata
);
  // The host starts idle; this model only reads.
  initial
  begin
    {hp_rd, hp_wr, hp_addr, hp_wdata} = '0;
  end
  // Read one word and return the denial seen at the edge that takes it.
  task automatic read(input logic [15:0] a, output logic den);
    @(posedge pclk);
    hp_rd   <= 1'b1;
    hp_addr <= a;
    @(posedge pclk);
    while (hp_wait === 1'b1)
      @(posedge pclk);
    den = hp_denied;
    hp_rd   <= 1'b0;
    hp_addr <= ~a;  // A released address shows its inverse, so stale values never match.
  endtask
endmodule

// >>> verif/onchip_memory_map_mode_control_test.sv
// Self-checking bench for the memory map and mode status block.
`timescale 1ns/1ps
module onchip_memory_map_mode_control_test;
  import memmap_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_select, memory_protect, err;
  logic soft_reset, prog_rd, prog_wr, prog_ram_hit, prog_rom_hit, prog_ext, data_rd, data_wr;
  logic data_ram_hit, data_page0, data_ext, hp_rd, hp_wr, hp_wait, hp_denied, ext_instr_req;
  logic ext_instr_grant, ext_instr_denied, vec_take, pc_load, clock_output_pin, overflow_mode;
  logic fractional_mode, multiply_accumulate_op, multiply_subtract_op, store_req, den;
  logic [3:0]  pstrb;
  logic [4:0]  vec_num, store_shift;
  logic [11:0] paddr;
  logic [15:0] prog_wdata, prog_rdata, data_addr, data_wdata, data_rdata, hp_addr, hp_wdata;
  logic [15:0] hp_rdata;
  logic [22:0] prog_addr, pc_value, ext_addr_pins;
  logic [31:0] pwdata, prdata, product_in, product_out, store_data, rd;
  logic [39:0] acc_in;
  int          failures = 0;
  int          samples_checked = 0;
  memmap_mode i_memmap_mode (.*);
  host_model  i_host_model (.*);
  // Free-running 8 ns clock.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_reset_and_map;
    apb(1'b0, MODE_OFS, 16'h0000);
    chk(rd, 32'h0000ffc0);
    chk(pc_value, 23'h00ff80);
    apb(1'b0, 12'h008, 16'h0000);
    chk(err, 1'b1);
    data_rd   <= 1'b1;
    data_addr <= 16'h8000;
    prog_rd   <= 1'b1;
    prog_addr <= 23'h000010;
    #1 chk({data_ram_hit, data_ext}, 2'b01);
    apb(1'b1, MODE_OFS, 16'h01ef);
    #1 chk({data_ram_hit, data_ext, prog_ram_hit}, 3'b100);
    @(posedge pclk);
    prog_addr <= 23'h000100;
    #1 chk(prog_ram_hit, 1'b1);
    @(posedge pclk);
    prog_rd <= 1'b0;
    data_rd <= 1'b0;
    apb(1'b0, MODE_OFS, 16'h0000);
    chk(rd, 32'h000001ef);
    $display("reset and map test done");
  endtask
  task automatic t_vector_clock_sat;
    vec_take <= 1'b1;
    vec_num  <= 5'd3;
    overflow_mode <= 1'b1;
    fractional_mode <= 1'b1;
    multiply_accumulate_op <= 1'b1;
    product_in <= 32'h80000000;
    store_req  <= 1'b1;
    acc_in     <= 40'h0100000000;
    @(posedge pclk);
    {vec_take, multiply_accumulate_op, store_req} <= 3'b000;
    #1 chk({pc_load, pc_value}, {1'b1, 23'h00018c});
    chk({product_out, store_data}, {2{32'h7fffffff}});
    chk(clock_output_pin, 1'b1);
    @(posedge pclk);
    soft_reset <= 1'b1;
    #1 chk(clock_output_pin, 1'b1);
    @(posedge pclk);
    soft_reset <= 1'b0;
    apb(1'b0, MODE_OFS, 16'h0000);
    chk(rd, 32'h000001c0);
    $display("vector clock saturate test done");
  endtask
  // Both RAM kinds written in one cycle, read back, then page 0, ROM off and pin hold.
  task automatic t_ram_paths;
    {data_wr, prog_wr, multiply_subtract_op} <= 3'b111;
    data_addr  <= 16'h4000;
    data_wdata <= 16'h5a3c;
    prog_addr  <= 23'h038000;
    prog_wdata <= 16'hc3a5;
    @(posedge pclk);
    {data_wr, prog_wr, multiply_subtract_op} <= 3'b000;
    {data_rd, prog_rd} <= 2'b11;
    @(posedge pclk);
    data_addr <= 16'h0040;
    prog_addr <= 23'h00c000;
    #1 chk({data_rdata, prog_rdata}, {16'h5a3c, 16'hc3a5});
    chk(product_out, 32'h80000000);
    chk(ext_addr_pins, 23'h000010);
    chk({data_page0, data_ext, data_ram_hit, prog_rom_hit, prog_ext}, 5'b10001);
    @(posedge pclk);
    {data_rd, prog_rd} <= 2'b00;
    #1 chk(ext_addr_pins, 23'h00c000);
    @(posedge pclk);
    $display("ram paths test done");
  endtask
  task automatic t_protect;
    memory_protect <= 1'b1;
    ext_instr_req  <= 1'b1;
    #1 chk({ext_instr_denied, ext_instr_grant}, 2'b10);
    i_host_model.read(16'h6000, den);
    chk(den, 1'b1);
    data_rd <= 1'b1;
    fork
      i_host_model.read(16'h4000, den);
      begin
        repeat (2) @(posedge pclk);
        #1 chk(hp_wait, 1'b1);
        @(posedge pclk);
        data_rd <= 1'b0;
      end
    join
    chk(den, 1'b0);
    #1 chk(hp_rdata, 16'h5a3c);
    $display("protect test done");
  endtask
  // Main sequence: quiet inputs, 20-cycle reset, then the scenarios.
  initial
  begin
    {presetn, psel, penable, pwrite, memory_protect, soft_reset, prog_rd, prog_wr} = '0;
    {data_rd, data_wr, ext_instr_req, vec_take, overflow_mode, fractional_mode} = '0;
    {multiply_accumulate_op, multiply_subtract_op, store_req, vec_num, store_shift} = '0;
    {paddr, pwdata, prog_addr, prog_wdata, data_addr, data_wdata, product_in, acc_in} = '0;
    pstrb = 4'h3;
    rom_select = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset_and_map();
    t_vector_clock_sat();
    t_ram_paths();
    t_protect();
    tally_and_finish();
  end
  // Watchdog: the scenarios need well under a few hundred cycles.
  initial
  begin
    repeat (3000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
endmodule
